// ===== rtl/fecw_device.sv
// Device end: configuration word and the front-end logic it steers.
// Assumes pins other than inputEnableN are asynchronous and pass a synchroniser first.
module fecw_device #(
  parameter int IN_W = 14
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // Control word path
  fecw_if.dev                  cw,
  // Pins
  input  wire logic            extSyncIn,
  input  wire logic            inputEnableN,
  input  wire logic [2:0]      gainAdjustPins,
  input  wire logic [IN_W-1:0] sampleIn,
  input  wire logic            offsetFreqSerialData,
  input  wire logic            offsetFreqSerialFrame,
  // Filter return path
  input  wire logic [23:0]     cicData,
  input  wire logic            cicValid,
  // Outputs
  output logic [IN_W+14:0]     shifterOut,
  output logic                 decimDump,
  output logic [23:0]          halfbandData,
  output logic                 halfbandValid,
  output logic [31:0]          ncoPhase,
  output logic                 syncOutClkSel,
  output logic                 frontEndReset,
  output logic                 backEndReset,
  output logic [31:0]          configWord
);
  localparam int SH_W = IN_W + 15;
  localparam int PW   = IN_W + 6;

  // ****************************************
  // Pin synchronisation
  // ****************************************
  logic [PW-1:0] pinLevel;  // Synchronised pins
  logic [PW-1:0] pinRise;   // Rising edges
  fecw_pin_sync #(.W(PW)) uSync (
    .clk   (clk),
    .rst   (rst),
    .pinIn ({extSyncIn, offsetFreqSerialFrame, offsetFreqSerialData, gainAdjustPins, sampleIn}),
    .level (pinLevel),
    .rise  (pinRise)
  );

  logic            syncEv;    // External sync event
  logic            frameEv;   // Offset frame start
  logic            serBit;    // Offset serial bit
  logic [2:0]      gainPins;  // Gain adjust level
  logic [IN_W-1:0] sample;    // Input sample
  logic            enActive;  // Input enable active
  assign syncEv   = pinRise[PW-1];
  assign frameEv  = pinRise[PW-2];
  assign serBit   = pinLevel[PW-3];
  assign gainPins = pinLevel[IN_W+2:IN_W];
  assign sample   = pinLevel[IN_W-1:0];
  assign enActive = ~inputEnableN;  // Same-clock strobe, no sync

  // ****************************************
  // Control word capture
  // ****************************************
  localparam int PHASE_W = fecw_pkg::PHASE_W;
  logic [31:0]        cfg_r;        // Configuration word
  logic [31:0]        holdFreq_r;   // Frequency holding
  logic [PHASE_W-1:0] holdPhase_r;  // Phase holding
  logic               rstSync_r;    // Sync resets both ends

  // Word writes from the host, all on this clock
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r       <= fecw_pkg::CFG_RESET_VAL;
      holdFreq_r  <= '0;
      holdPhase_r <= '0;
      rstSync_r   <= 1'b0;
    end else if (cw.cwWrite) begin
      case (cw.cwIndex)
        fecw_pkg::CW_CONFIG: cfg_r <= cw.cwData & fecw_pkg::CFG_USED_MASK;
        fecw_pkg::CW_CENTER: holdFreq_r <= cw.cwData;
        fecw_pkg::CW_PHASE:  holdPhase_r <= cw.cwData[PHASE_W-1:0];
        fecw_pkg::CW_RESET:  rstSync_r <= cw.cwData[fecw_pkg::RST_SYNC_BIT];
        default: ;  // Other words belong elsewhere
      endcase
    end
  end
  assign configWord    = cfg_r;
  assign syncOutClkSel = cfg_r[fecw_pkg::CFG_SYNCCLK];

  // ****************************************
  // Sync-driven resets
  // ****************************************
  // One-cycle reset pulse to both halves
  always_ff @(posedge clk) begin
    if (rst) begin
      frontEndReset <= 1'b0;
      backEndReset  <= 1'b0;
    end else begin
      frontEndReset <= syncEv & rstSync_r;
      backEndReset  <= syncEv & rstSync_r;
    end
  end

  // ****************************************
  // Input format, mode and barrel shift
  // ****************************************
  logic [4:0]      gainSum;   // Unsaturated shift
  logic [3:0]      shiftAmt;  // Saturated shift
  logic [IN_W-1:0] fmtSample; // Two's complement sample
  logic [SH_W-1:0] extSample; // Sign-extended
  assign gainSum   = {1'b0, cfg_r[fecw_pkg::CFG_SG_LSB +: 4]} + {2'b00, gainPins};
  assign shiftAmt  = (gainSum > {1'b0, fecw_pkg::SG_MAX}) ? fecw_pkg::SG_MAX : gainSum[3:0];
  assign fmtSample = sample ^ {cfg_r[fecw_pkg::CFG_OFFBIN], {(IN_W-1){1'b0}}};
  assign extSample = {{15{fmtSample[IN_W-1]}}, fmtSample};

  // Gated mode holds, interpolated mode stuffs zeros
  always_ff @(posedge clk) begin
    if (rst) begin
      shifterOut <= '0;
    end else if (enActive) begin
      shifterOut <= extSample << shiftAmt;
    end else if (cfg_r[fecw_pkg::CFG_INTERP]) begin
      shifterOut <= '0;
    end
  end

  // ****************************************
  // Decimation counter
  // ****************************************
  logic [5:0] decCnt_r;  // Counts down to dump
  logic [5:0] preload;   // R-1 from the word
  assign preload = cfg_r[fecw_pkg::CFG_DEC_LSB +: 6];

  // Sync reload keeps several chips aligned
  always_ff @(posedge clk) begin
    if (rst) begin
      decCnt_r  <= '0;
      decimDump <= 1'b0;
    end else if (syncEv && cfg_r[fecw_pkg::CFG_CIC_SYNC]) begin
      decCnt_r  <= preload;
      decimDump <= 1'b0;
    end else if (enActive) begin
      decimDump <= (decCnt_r == 6'h00);
      decCnt_r  <= (decCnt_r == 6'h00) ? preload : decCnt_r - 6'h01;
    end else begin
      decimDump <= 1'b0;
    end
  end

  // ****************************************
  // Bypass path to halfband stages
  // ****************************************
  // Bypass hands on the low 24 shifter bits unfiltered
  always_ff @(posedge clk) begin
    if (rst) begin
      halfbandData  <= '0;
      halfbandValid <= 1'b0;
    end else if (cfg_r[fecw_pkg::CFG_BYPASS]) begin
      halfbandData  <= shifterOut[23:0];
      halfbandValid <= enActive;
    end else begin
      halfbandData  <= cicData;
      halfbandValid <= cicValid;
    end
  end

  // ****************************************
  // Serial offset frequency loader
  // ****************************************
  logic [31:0] offShift_r;  // Incoming bits
  logic [5:0]  offCnt_r;    // Bits still to come
  logic [31:0] offFreq_r;   // Completed offset word
  logic [5:0]  offLen;      // 8, 16, 24 or 32
  assign offLen = 6'(({4'h0, cfg_r[fecw_pkg::CFG_OFLEN_LSB +: 2]} + 6'h01) << 3);  // Code plus one, times eight

  // Frame starts a count; the last bit completes the word
  always_ff @(posedge clk) begin
    if (rst) begin
      offShift_r <= '0;
      offCnt_r   <= '0;
      offFreq_r  <= '0;
    end else if (frameEv) begin
      offCnt_r   <= offLen;
      offShift_r <= '0;
    end else if (offCnt_r != 6'h00) begin
      offShift_r <= {offShift_r[30:0], serBit};
      offCnt_r   <= offCnt_r - 6'h01;
      if (offCnt_r == 6'h01) begin
        offFreq_r <= {offShift_r[30:0], serBit};
      end
    end
  end

  // ****************************************
  // Carrier oscillator loading
  // ****************************************
  logic               loadPend_r;   // Held until next update
  logic               loadReq;      // Transfer requested now
  logic               ncoLoad;      // Transfer happens now
  logic [31:0]        actFreq_r;    // Active frequency
  logic [PHASE_W-1:0] actPhase_r;   // Active phase offset
  logic [31:0]        accum_r;      // Phase accumulator
  logic               zeroFb;       // Feedback forced to zero
  logic [31:0]        stepFreq;     // Frequency plus offset
  assign loadReq = (cw.cwWrite && cw.cwIndex == fecw_pkg::CW_XFER)
                 | (syncEv & cfg_r[fecw_pkg::CFG_NCO_SYNC]);
  assign ncoLoad = enActive & (loadReq | loadPend_r);

  // New request wins over the clear of an old one
  always_ff @(posedge clk) begin
    if (rst) begin
      loadPend_r <= 1'b0;
    end else if (loadReq && !enActive) begin
      loadPend_r <= 1'b1;
    end else if (ncoLoad) begin
      loadPend_r <= 1'b0;
    end
  end

  // Holding registers move to active ones
  always_ff @(posedge clk) begin
    if (rst) begin
      actFreq_r  <= '0;
      actPhase_r <= '0;
    end else if (ncoLoad) begin
      actFreq_r  <= holdFreq_r;
      actPhase_r <= holdPhase_r;
    end
  end

  assign zeroFb   = cfg_r[fecw_pkg::CFG_CLRACC]
                  | (ncoLoad & cfg_r[fecw_pkg::CFG_LOADZERO]);
  assign stepFreq = (ncoLoad ? holdFreq_r : actFreq_r)
                  + (cfg_r[fecw_pkg::CFG_OFFEN] ? offFreq_r : 32'h0000_0000);

  // Accumulates only on enabled samples
  always_ff @(posedge clk) begin
    if (rst) begin
      accum_r <= '0;
    end else if (enActive) begin
      accum_r <= (zeroFb ? 32'h0000_0000 : accum_r) + stepFreq;
    end
  end

  // Phase offset sits in the top bits of the phase
  always_ff @(posedge clk) begin
    if (rst) begin
      ncoPhase <= '0;
    end else begin
      ncoPhase <= accum_r + {actPhase_r, {(32-PHASE_W){1'b0}}};
    end
  end
endmodule : fecw_device

// ===== rtl/fecw_host.sv
// Host end: AXI4-Lite slave that sends control words to the device.
// Assumes software writes DATA then CMD; clock runs during loads.
module fecw_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Control word path
  fecw_if.host             cw
);
  logic        awHave_r;  // Address held
  logic [3:0]  awAddr_r;
  logic        wHave_r;   // Data held
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic [31:0] data_r;    // Word to send
  logic [4:0]  lastIdx_r; // Last index sent
  logic [31:0] sent_r;    // Words sent
  logic        doWrite;

  // ****************************************
  // Write channel
  // ****************************************
  assign s_axi_awready = ~awHave_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHave_r & ~s_axi_bvalid;
  assign doWrite       = awHave_r & wHave_r;

  // Address and data taken in either order
  always_ff @(posedge clk) begin
    if (rst) begin
      awHave_r <= 1'b0;
      awAddr_r <= '0;
      wHave_r  <= 1'b0;
      wData_r  <= '0;
      wStrb_r  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHave_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHave_r <= 1'b0;
      end
    end
  end

  // Register update, word launch and response
  always_ff @(posedge clk) begin
    if (rst) begin
      data_r       <= '0;
      lastIdx_r    <= '0;
      sent_r       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= fecw_pkg::RESP_OKAY;
      cw.cwWrite   <= 1'b0;
      cw.cwIndex   <= '0;
      cw.cwData    <= '0;
    end else begin
      cw.cwWrite <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= fecw_pkg::RESP_OKAY;
        case (awAddr_r)
          fecw_pkg::REG_DATA: begin
            for (int b = 0; b < 4; b++) begin
              if (wStrb_r[b]) data_r[8*b +: 8] <= wData_r[8*b +: 8];
            end
          end
          fecw_pkg::REG_CMD: begin
            cw.cwWrite <= 1'b1;
            cw.cwIndex <= wData_r[4:0];
            cw.cwData  <= (wData_r[4:0] == fecw_pkg::CW_CONFIG)
                        ? (data_r & fecw_pkg::CFG_USED_MASK) : data_r;
            lastIdx_r  <= wData_r[4:0];
            sent_r     <= sent_r + 32'h0000_0001;
          end
          default: s_axi_bresp <= fecw_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;

  // One-cycle read answer
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= fecw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= fecw_pkg::RESP_OKAY;
      case (s_axi_araddr)
        fecw_pkg::REG_DATA:   s_axi_rdata <= data_r;
        fecw_pkg::REG_CMD:    s_axi_rdata <= {27'h000_0000, lastIdx_r};
        fecw_pkg::REG_STATUS: s_axi_rdata <= sent_r;
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= fecw_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : fecw_host

// ===== rtl/fecw_if.sv
// Control-word write path from host end to device end.
// Assumes both ends share the front-end clock.
interface fecw_if (
  input wire logic clk
);
  logic        cwWrite;  // One-cycle write strobe
  logic [4:0]  cwIndex;  // Control word index
  logic [31:0] cwData;   // Control word value

  modport host (input clk, output cwWrite, output cwIndex, output cwData);
  modport dev  (input clk, input cwWrite, input cwIndex, input cwData);
endinterface : fecw_if

// ===== rtl/fecw_pin_sync.sv
// Two-stage synchroniser for a group of pins, with rising-edge pulses.
// Assumes inputs are asynchronous to clk.
module fecw_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Pins and results
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] meta_r;  // First stage, read only by second
  logic [W-1:0] stab_r;  // Second stage
  logic [W-1:0] prev_r;  // Edge reference

  // ****************************************
  // Synchroniser chain
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      stab_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= pinIn;
      stab_r <= meta_r;
      prev_r <= stab_r;
    end
  end

  assign level = stab_r;
  assign rise  = stab_r & ~prev_r;  // Single-cycle event
endmodule : fecw_pin_sync

// ===== rtl/fecw_pkg.sv
// Constants shared by the configuration-word host end and device end.
// Assumes both ends run on the one front-end clock.
package fecw_pkg;

  // ****************************************
  // Control word indices
  // ****************************************
  localparam logic [4:0] CW_CONFIG = 5'h00;  // Chip configuration word
  localparam logic [4:0] CW_CENTER = 5'h03;  // Centre frequency holding
  localparam logic [4:0] CW_PHASE  = 5'h04;  // Phase offset holding
  localparam logic [4:0] CW_XFER   = 5'h05;  // Holding-to-active transfer
  localparam logic [4:0] CW_RESET  = 5'h1B;  // Reset control word

  // ****************************************
  // Configuration word fields
  // ****************************************
  localparam int          CFG_NCO_SYNC  = 20;
  localparam int          CFG_CIC_SYNC  = 19;
  localparam int          CFG_OFFBIN    = 18;
  localparam int          CFG_INTERP    = 17;
  localparam int          CFG_SG_LSB    = 13;
  localparam int          CFG_DEC_LSB   = 7;
  localparam int          CFG_BYPASS    = 6;
  localparam int          CFG_OFLEN_LSB = 4;
  localparam int          CFG_SYNCCLK   = 3;
  localparam int          CFG_CLRACC    = 2;
  localparam int          CFG_OFFEN     = 1;
  localparam int          CFG_LOADZERO  = 0;
  localparam int          RST_SYNC_BIT  = 22;
  localparam int          PHASE_W       = 10;
  localparam logic [31:0] CFG_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] CFG_USED_MASK = 32'h001F_FFFF;
  localparam logic [3:0]  SG_MAX        = 4'hF;

  // ****************************************
  // Host register map (byte offsets)
  // ****************************************
  localparam logic [3:0] REG_DATA   = 4'h0;  // Word to send
  localparam logic [3:0] REG_CMD    = 4'h4;  // Write sends to index
  localparam logic [3:0] REG_STATUS = 4'h8;  // Words sent count
  localparam logic [1:0] RESP_OKAY  = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : fecw_pkg

// ===== sim/fecw_checker.sv
// Checker for the control-word link and the device's config outputs.
// Assumes one clock domain; placed beside the interface in the bench top.
module fecw_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Control word link
  input wire logic        cwWrite,
  input wire logic [4:0]  cwIndex,
  input wire logic [31:0] cwData,
  // Device outputs
  input wire logic [31:0] configWord,
  input wire logic        syncOutClkSel,
  input wire logic        frontEndReset,
  input wire logic        backEndReset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Every assertion shares the one clock and reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************
  // Sequences
  // ****************************************
  // Config word offered on the link
  sequence cfgSend;
    cwWrite && cwIndex == fecw_pkg::CW_CONFIG;
  endsequence
  // Start of a sync-driven reset
  sequence resetStart;
    $rose(frontEndReset);
  endsequence

  // ****************************************
  // Assertions
  // ****************************************
  chk_strobe_single: assert property (cwWrite |=> !cwWrite)
    else $error("link strobe longer than one cycle");
  chk_reserved_link: assert property (cfgSend |-> cwData[31:21] == 11'h000)
    else $error("reserved config bits sent nonzero");
  chk_config_capture: assert property (cfgSend |=> configWord == ($past(cwData) & fecw_pkg::CFG_USED_MASK))
    else $error("config word not captured");
  // Reset pulses excuse a change too, though the device keeps the word through them
  chk_config_hold: assert property ($changed(configWord) |->
                                    ($past(cwWrite) && $past(cwIndex) == fecw_pkg::CW_CONFIG)
                                    || $past(frontEndReset) || frontEndReset)
    else $error("config word changed without a write");
  chk_reserved_out: assert property (configWord[31:21] == 11'h000)
    else $error("reserved config bits nonzero");
  chk_clock_select: assert property (syncOutClkSel == configWord[3])
    else $error("sync output clock select wrong");
  chk_reset_both: assert property (resetStart |-> backEndReset)
    else $error("back-end reset missing");
  chk_reset_pulse: assert property (frontEndReset |=> !frontEndReset)
    else $error("front-end reset longer than one cycle");
  cov_cfg_send: cover property (cfgSend);
endmodule // fecw_checker

// ===== sim/fecw_tb_top.sv
// Bench top: host end and device end joined by the control-word interface.
// Assumes a 40 MHz clock; AXI signals change by NBA after rising edges.
module fecw_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk, rst, extSyncIn, inputEnableN, decimDump, halfbandValid, syncOutClkSel;
  logic        offsetFreqSerialData, offsetFreqSerialFrame, cicValid;
  logic        frontEndReset, backEndReset, s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_arvalid, s_axi_arready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, configWord, ncoPhase;
  logic [2:0]  gainAdjustPins;
  logic [13:0] sampleIn;
  logic [23:0] cicData, halfbandData;
  logic [28:0] shifterOut;
  int          nErrors, checked;
  logic [31:0] sentQ[$];  // Model: words sent over the link

  // ****************************************
  // Instances
  // ****************************************
  fecw_if cwBus (.clk(clk));
  fecw_host u_fecw_host (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cw(cwBus));
  // Serial pins and filter valid driven by the bench
  fecw_device #(.IN_W(14)) u_fecw_device (.clk, .rst, .cw(cwBus), .extSyncIn, .inputEnableN, .gainAdjustPins,
    .sampleIn, .offsetFreqSerialData, .offsetFreqSerialFrame, .cicData, .cicValid, .shifterOut,
    .decimDump, .halfbandData, .halfbandValid, .ncoPhase, .syncOutClkSel, .frontEndReset, .backEndReset, .configWord);
  fecw_checker u_chk (.clk, .rst, .cwWrite(cwBus.cwWrite), .cwIndex(cwBus.cwIndex), .cwData(cwBus.cwData),
    .configWord, .syncOutClkSel, .frontEndReset, .backEndReset);

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, nErrors);
    if (nErrors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // AXI write; bready stays high throughout
  task automatic axiW(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  // AXI read; rready stays high throughout
  task automatic axiR(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Data then command: one control word over the link
  task automatic sendWord(input logic [4:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axiW(fecw_pkg::REG_DATA, d, r);
    axiW(fecw_pkg::REG_CMD, {27'h000_0000, idx}, r);
    chk("cmd resp", 32'h0000_0000, {30'h0000_0000, r});
    sentQ.push_back(d);
    repeat (2) @(posedge clk);
  endtask
  // Sync pin held long enough to pass the synchroniser
  task automatic syncPulse();
    extSyncIn <= 1'b1;
    repeat (4) @(posedge clk);
    extSyncIn <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // Phase advance over one enabled cycle
  task automatic phaseStep(output logic [31:0] dp);
    logic [31:0] p;
    @(posedge clk);
    p = ncoPhase;
    @(posedge clk);
    dp = ncoPhase - p;
  endtask
  // Model of the input shifter
  function automatic logic [28:0] expShift(logic [13:0] s, logic ob, int sh);
    if (ob) s[13] = ~s[13];
    return {{15{s[13]}}, s} << ((sh > 15) ? 15 : sh);
  endfunction

  // Watchdog: whole run is a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk);
    nErrors++;
    conclude();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d, q, cfg, o;
    logic [1:0]  r;
    logic [28:0] e;
    int          sg, pins, dec, n;
    rst = 1'b1;
    {extSyncIn, inputEnableN, gainAdjustPins, sampleIn, cicData, cicValid} = '0;
    {offsetFreqSerialData, offsetFreqSerialFrame} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    nErrors = 0;
    checked = 0;
    void'($urandom(86136));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Host registers: read-back, unmapped read, refused status write
    d = $urandom;
    axiW(fecw_pkg::REG_DATA, d, r);
    axiR(fecw_pkg::REG_DATA, q, r);
    chk("data reg", d, q);
    axiR(4'hC, q, r);
    chk("unmapped resp", {30'h0000_0000, fecw_pkg::RESP_SLVERR}, {30'h0000_0000, r});
    axiW(fecw_pkg::REG_STATUS, d, r);
    chk("status write resp", {30'h0000_0000, fecw_pkg::RESP_SLVERR}, {30'h0000_0000, r});
    // Format, gain, bypass and mode combinations
    for (int k = 0; k < 8; k++) begin
      sg = $urandom_range(15);
      pins = $urandom_range(7);
      gainAdjustPins <= 3'(pins);
      sampleIn <= 14'($urandom);
      cicData <= 24'($urandom);
      cicValid <= 1'($urandom);
      cfg = (32'(k % 2) << 18) | (32'(k / 4) << 17) | (32'(sg) << 13) | 32'h0000_0180 | (32'((k / 2) % 2) << 6);
      cfg = cfg | (32'((k / 2) % 2) << 3);
      sendWord(fecw_pkg::CW_CONFIG, cfg | 32'hFFE0_0000);  // Reserved bits set on purpose
      repeat (4) @(posedge clk);
      chk("config word", cfg, configWord);
      chk("sync clk sel", 32'((k / 2) % 2), {31'h0000_0000, syncOutClkSel});
      e = expShift(sampleIn, 1'(k % 2), sg + pins);
      chk("shifter", {3'h0, e}, {3'h0, shifterOut});
      if ((k / 2) % 2 == 1) chk("halfband bypass", {8'h00, e[23:0]}, {8'h00, halfbandData});
      else chk("halfband filtered", {8'h00, cicData}, {8'h00, halfbandData});
      chk("halfband valid", ((k / 2) % 2 == 1) ? 32'h0000_0001 : 32'(cicValid), {31'h0000_0000, halfbandValid});
      inputEnableN <= 1'b1;
      repeat (6) @(posedge clk);
      chk("disabled shifter", (k / 4 == 1) ? 32'h0000_0000 : {3'h0, e}, {3'h0, shifterOut});
      inputEnableN <= 1'b0;
    end
    // Decimation period at both ends of the range and one inside
    for (int i = 0; i < 3; i++) begin
      dec = (i == 0) ? 4 : (i == 1) ? 32 : $urandom_range(31, 5);
      sg = (dec == 4) ? 15 : (dec == 32) ? 0 : int'($floor(25.0 - 5.0 * $ln(real'(dec)) / $ln(2.0)));
      sendWord(fecw_pkg::CW_CONFIG, (32'(sg) << 13) | (32'(dec - 1) << 7));
      do @(posedge clk); while (!decimDump);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (!decimDump);
      chk("dump period", 32'(dec), 32'(n));
    end
    // Oscillator: transfer word, held word, sync load while disabled
    d = $urandom | 32'h0000_0001;
    sendWord(fecw_pkg::CW_CENTER, d);
    sendWord(fecw_pkg::CW_XFER, 32'h0000_0000);
    phaseStep(q);
    chk("freq step", d, q);
    cfg = $urandom | 32'h0000_0002;
    sendWord(fecw_pkg::CW_CENTER, cfg);
    syncPulse();
    phaseStep(q);
    chk("sync ignored", d, q);
    sendWord(fecw_pkg::CW_CONFIG, 32'h0010_0000);
    inputEnableN <= 1'b1;
    syncPulse();
    inputEnableN <= 1'b0;
    repeat (2) @(posedge clk);
    phaseStep(q);
    chk("sync freq", cfg, q);
    sendWord(fecw_pkg::CW_CONFIG, 32'h0000_0004);
    phaseStep(q);
    chk("cleared accum", 32'h0000_0000, q);
    // Serial offset word at every length, MSB first
    for (int L = 0; L < 4; L++) begin
      sendWord(fecw_pkg::CW_CONFIG, 32'h0000_0002 | (32'(L) << 4));
      o = $urandom >> (24 - 8 * L);
      offsetFreqSerialFrame <= 1'b1;
      for (int i = 8 * L + 7; i >= 0; i--) begin
        @(posedge clk);
        offsetFreqSerialData <= o[i];
      end
      offsetFreqSerialFrame <= 1'b0;
      repeat (4) @(posedge clk);
      phaseStep(q);
      chk("offset freq", cfg + o, q);
    end
    // Sync-driven reset, enabled then disabled
    for (int b = 1; b >= 0; b--) begin
      sendWord(fecw_pkg::CW_RESET, 32'(b) << 22);
      extSyncIn <= 1'b1;
      n = 0;
      repeat (8) begin
        @(posedge clk);
        if (frontEndReset === 1'b1 && backEndReset === 1'b1) n++;
      end
      extSyncIn <= 1'b0;
      repeat (6) @(posedge clk);
      chk("sync reset", 32'(b), 32'(n));
    end
    axiR(fecw_pkg::REG_STATUS, q, r);
    chk("words sent", 32'(sentQ.size()), q);
    conclude();
  end
endmodule // fecw_tb_top
